// File: rtl/pwg_pkg.sv
// pwg_pkg: constants and types of the cascadable 48-channel pulse width generator
`default_nettype none
package pwg_pkg;
	// ==========================================================
	// frame geometry
	localparam int unsigned CHANNELS    = 48;
	localparam int unsigned WIDTH_BITS  = 12;
	localparam int unsigned CMD_BITS    = 8;
	localparam int unsigned TRIM_BITS   = 6;
	localparam int unsigned FRAME_BITS  = CHANNELS * WIDTH_BITS + CMD_BITS;
	localparam int unsigned CMD_POS     = 0;
	localparam int unsigned DATA_POS    = CMD_BITS;
	localparam logic [9:0]  FRAME_LAST  = 10'h0_247;
	localparam logic [9:0]  BIT_CNT_RST = 10'h0_000;
	localparam logic [9:0]  BIT_CNT_ONE = 10'h0_001;

	// ==========================================================
	// modulation counter and scaling
	localparam logic [11:0] MOD_CNT_RST  = 12'h0_000;
	localparam logic [11:0] MOD_CNT_LAST = 12'h0_FFF;
	localparam logic [6:0]  TRIM_OFFSET  = 7'h0_20;
	localparam logic [18:0] SCALE_DIV    = 19'h0_0060;
	localparam logic [5:0]  TRIM_RST     = 6'h0_0;
	localparam logic [11:0] WIDTH_RST    = 12'h0_000;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned BLANK_TIME_NS  = 50000;
	localparam int unsigned STROBE_MAX_NS  = 5000;
	localparam int unsigned BLANK_CYC      = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] BLANK_CNT_MAX  = 11'(BLANK_CYC);
	localparam logic [10:0] BLANK_CNT_RST  = 11'h0_000;
	localparam logic [5:0]  NOMINAL_WIDTH_IDX_RST   = 6'h0_0;
	localparam logic [5:0]  NOMINAL_WIDTH_IDX_LAST  = 6'h0_2F;

	// ==========================================================
	// commands (upper nibble of the command field)
	typedef enum logic [3:0] {
		PWG_CMD_UPDATE_SYNC  = 4'h0,
		PWG_CMD_UPDATE_ASYNC = 4'h1,
		PWG_CMD_TRIM_LOAD    = 4'h2,
		PWG_CMD_OUT_ENABLE   = 4'h3,
		PWG_CMD_OUT_DISABLE  = 4'h4,
		PWG_CMD_SELF_TEST    = 4'h5,
		PWG_CMD_PHASE_TOGGLE = 4'h6,
		PWG_CMD_SCALE_TOGGLE = 4'h7
	} pwg_cmd_e;

	typedef enum logic [1:0] {
		PWG_IDLE,
		PWG_WALK,
		PWG_DONE
	} pwg_state_e;

	// command field of the status frame
	typedef struct packed {
		logic [3:0] cmd_hi;
		logic       open_self_test;
		logic       frame_sync_error;
		logic       phase_offset_on;
		logic       scaling_disable;
	} pwg_status_cmd_s;

	// one channel field of the status frame
	typedef struct packed {
		logic [4:0] zero;
		logic       open_fault;
		logic [5:0] trim_value;
	} pwg_status_nominal_width_s;

	// device flags shown on ports
	typedef struct packed {
		logic outputs_enabled;
		logic open_self_test;
		logic frame_sync_error;
		logic phase_offset_on;
		logic scaling_disable;
	} pwg_flags_s;

	localparam pwg_flags_s FLAGS_RST = '{default: 1'b0};
endpackage
`default_nettype wire

// File: rtl/pwg_generator.sv
// pwg_generator: 48-channel pulse width generator with cascadable serial frame interface
`default_nettype none
module pwg_generator (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  shift_clock_in_i,
	input  wire logic                  serial_in_i,
	input  wire logic                  latch_strobe_pin_i,
	input  wire logic                  modulation_clock_i,
	input  wire logic                  open_string_n_i,
	output logic                       serial_out_o,
	output logic                       shift_clock_out_o,
	output logic [47:0]                channel_o,
	output pwg_pkg::pwg_flags_s        flags_o
);
	// ==========================================================
	// scaling multiplier
	function automatic logic [11:0] scale_width(input logic [11:0] nominal, input logic [5:0] trim);
		logic [18:0] prod;
		prod = 19'(nominal) * 19'({1'b0, trim} + pwg_pkg::TRIM_OFFSET);
		return 12'(prod / pwg_pkg::SCALE_DIV);
	endfunction

	// ==========================================================
	// declarations
	logic [pwg_pkg::FRAME_BITS-1:0] frame_shifter;
	logic [pwg_pkg::FRAME_BITS-1:0] status_word;
	logic [9:0]                     bit_cnt;
	logic                           status_tgl;
	logic                           status_seen;
	logic                           link_rst_req;
	logic [2:0]                     strobe_sync;
	logic [2:0]                     mod_sync;
	logic [1:0]                     open_sync;
	logic [1:0]                     sclk_sync;
	logic [10:0]                    blank_cnt;
	logic [11:0]                    mod_cnt;
	logic [11:0]                    staged_width_reg [pwg_pkg::CHANNELS];
	logic [11:0]                    active_width_reg [pwg_pkg::CHANNELS];
	logic [5:0]                     trim_value [pwg_pkg::CHANNELS];
	logic [47:0]                    open_fault_bits;
	logic [7:0]                     command_field;
	logic [5:0]                     nominal_width_idx;
	logic                           sync_pending;
	pwg_pkg::pwg_state_e            state;
	pwg_pkg::pwg_flags_s            flags;

	// ==========================================================
	// decoding
	wire                            latch_strobe  = strobe_sync[1];
	wire                            strobe_rise   = strobe_sync[1] & ~strobe_sync[2];
	wire                            blank_hit     = latch_strobe & (blank_cnt == pwg_pkg::BLANK_CNT_MAX);
	wire                            soft_rst      = rst_i | blank_hit;
	wire                            mod_edge      = mod_sync[1] & ~mod_sync[2];
	wire                            period_start  = mod_edge & (mod_cnt == pwg_pkg::MOD_CNT_LAST);
	wire                            open_fault    = ~open_sync[1];
	wire [3:0]                      cmd_hi        = command_field[7:4];
	wire [3:0]                      new_cmd_hi    = frame_shifter[pwg_pkg::CMD_POS+7 -: 4];
	wire                            is_sync_upd   = cmd_hi == pwg_pkg::PWG_CMD_UPDATE_SYNC;
	wire                            is_async_upd  = cmd_hi == pwg_pkg::PWG_CMD_UPDATE_ASYNC;
	wire                            is_trim_load  = cmd_hi == pwg_pkg::PWG_CMD_TRIM_LOAD;
	wire                            new_enable    = new_cmd_hi == pwg_pkg::PWG_CMD_OUT_ENABLE;
	wire                            restart_mod   = strobe_rise & new_enable & ~flags.outputs_enabled;
	wire [11:0]                     nominal_width = frame_shifter[pwg_pkg::DATA_POS + 12*nominal_width_idx +: 12];
	wire [11:0]                     scaled_width  = flags.scaling_disable ? nominal_width :
	                                                scale_width(nominal_width, trim_value[nominal_width_idx]);
	wire                            walk_last     = nominal_width_idx == pwg_pkg::NOMINAL_WIDTH_IDX_LAST;
	wire                            status_fresh  = status_tgl != status_seen;

	// ==========================================================
	// link side: shift chain on the shift clock
	assign shift_clock_out_o = shift_clock_in_i;
	assign serial_out_o      = frame_shifter[pwg_pkg::FRAME_BITS-1];

	// reset clears the chain at once: the shift clock stands still outside frames,
	// so a reset released on shift edges would swallow the first bits of the next frame
	// first edge after a latch shifts the status word in place of the finished frame
	always_ff @(posedge shift_clock_in_i or posedge link_rst_req) begin
		if (link_rst_req) begin
			frame_shifter <= '0;
			bit_cnt       <= pwg_pkg::BIT_CNT_RST;
			status_seen   <= 1'b0;
		end else if (status_fresh) begin
			frame_shifter <= {status_word[pwg_pkg::FRAME_BITS-2:0], serial_in_i};
			bit_cnt       <= pwg_pkg::BIT_CNT_ONE;
			status_seen   <= status_tgl;
		end else begin
			frame_shifter <= {frame_shifter[pwg_pkg::FRAME_BITS-2:0], serial_in_i};
			bit_cnt       <= (bit_cnt == pwg_pkg::FRAME_LAST) ? pwg_pkg::BIT_CNT_RST : 10'(bit_cnt + 10'h0_001);
		end
	end

	// ==========================================================
	// input synchronisers
	always_ff @(posedge sys_clk_i) begin
		strobe_sync <= {strobe_sync[1:0], latch_strobe_pin_i};
		mod_sync    <= {mod_sync[1:0], modulation_clock_i};
		open_sync   <= {open_sync[0], open_string_n_i};
		sclk_sync   <= {sclk_sync[0], shift_clock_in_i};
	end

	// ==========================================================
	// long strobe: blank and reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i | ~latch_strobe) begin
			blank_cnt <= pwg_pkg::BLANK_CNT_RST;
		end else if (!blank_hit) begin
			blank_cnt <= 11'(blank_cnt + 11'h0_001);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		link_rst_req <= soft_rst;
	end

	// ==========================================================
	// modulation counter
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst | restart_mod) begin
			mod_cnt <= pwg_pkg::MOD_CNT_RST;
		end else if (mod_edge) begin
			mod_cnt <= 12'(mod_cnt + 12'h0_001);
		end
	end

	// ==========================================================
	// command capture and channel walk
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst) begin
			state         <= pwg_pkg::PWG_IDLE;
			command_field <= 8'h0_0;
			nominal_width_idx      <= pwg_pkg::NOMINAL_WIDTH_IDX_RST;
			flags         <= pwg_pkg::FLAGS_RST;
			status_tgl    <= 1'b0;
		end else begin
			unique case (state)
				pwg_pkg::PWG_IDLE: begin
					if (strobe_rise) begin
						command_field          <= frame_shifter[pwg_pkg::CMD_POS +: 8];
						flags.frame_sync_error <= (bit_cnt != pwg_pkg::BIT_CNT_RST) | sclk_sync[1];
						nominal_width_idx               <= pwg_pkg::NOMINAL_WIDTH_IDX_RST;
						state                  <= pwg_pkg::PWG_WALK;
						unique case (new_cmd_hi)
							pwg_pkg::PWG_CMD_OUT_ENABLE:   flags.outputs_enabled <= 1'b1;
							pwg_pkg::PWG_CMD_OUT_DISABLE:  flags.outputs_enabled <= 1'b0;
							pwg_pkg::PWG_CMD_SELF_TEST:    flags.open_self_test  <= ~flags.open_self_test;
							pwg_pkg::PWG_CMD_PHASE_TOGGLE: flags.phase_offset_on <= ~flags.phase_offset_on;
							pwg_pkg::PWG_CMD_SCALE_TOGGLE: flags.scaling_disable <= ~flags.scaling_disable;
							default: begin
							end
						endcase
					end
				end
				pwg_pkg::PWG_WALK: begin
					nominal_width_idx <= 6'(nominal_width_idx + 6'h0_1);
					if (walk_last) begin
						state <= pwg_pkg::PWG_DONE;
					end
				end
				pwg_pkg::PWG_DONE: begin
					status_tgl <= ~status_tgl;
					state      <= pwg_pkg::PWG_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// per-channel storage
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst) begin
			for (int i = 0; i < pwg_pkg::CHANNELS; i++) begin
				staged_width_reg[i] <= pwg_pkg::WIDTH_RST;
				active_width_reg[i] <= pwg_pkg::WIDTH_RST;
				trim_value[i]       <= pwg_pkg::TRIM_RST;
			end
		end else begin
			if (period_start & sync_pending) begin
				for (int i = 0; i < pwg_pkg::CHANNELS; i++) begin
					active_width_reg[i] <= staged_width_reg[i];
				end
			end
			if (state == pwg_pkg::PWG_WALK) begin
				if (is_sync_upd | is_async_upd) begin
					staged_width_reg[nominal_width_idx] <= scaled_width;
				end
				if (is_async_upd) begin
					active_width_reg[nominal_width_idx] <= scaled_width;
				end
				if (is_trim_load) begin
					trim_value[nominal_width_idx] <= nominal_width[pwg_pkg::TRIM_BITS-1:0];
				end
			end
		end
	end

	// a new sync update wins over a period boundary in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst) begin
			sync_pending <= 1'b0;
		end else if ((state == pwg_pkg::PWG_DONE) & is_sync_upd) begin
			sync_pending <= 1'b1;
		end else if ((state == pwg_pkg::PWG_DONE) & is_async_upd) begin
			sync_pending <= 1'b0;
		end else if (period_start) begin
			sync_pending <= 1'b0;
		end
	end

	// ==========================================================
	// open-string faults: set wins over the clear at status load
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst) begin
			open_fault_bits <= '0;
		end else begin
			for (int i = 0; i < pwg_pkg::CHANNELS; i++) begin
				if (open_fault & channel_o[i]) begin
					open_fault_bits[i] <= 1'b1;
				end else if (state == pwg_pkg::PWG_DONE) begin
					open_fault_bits[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// status word, held steady until the next latch
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst) begin
			status_word <= '0;
		end else if (state == pwg_pkg::PWG_DONE) begin
			status_word[pwg_pkg::CMD_POS +: 8] <= pwg_pkg::pwg_status_cmd_s'{cmd_hi, flags.open_self_test,
				flags.frame_sync_error, flags.phase_offset_on, flags.scaling_disable};
			for (int i = 0; i < pwg_pkg::CHANNELS; i++) begin
				status_word[pwg_pkg::DATA_POS + 12*i +: 12] <= pwg_pkg::pwg_status_nominal_width_s'{5'h0_0,
					open_fault_bits[i], trim_value[i]};
			end
		end
	end

	// ==========================================================
	// channel outputs
	always_ff @(posedge sys_clk_i) begin
		if (soft_rst) begin
			channel_o <= '0;
		end else begin
			for (int i = 0; i < pwg_pkg::CHANNELS; i++) begin
				channel_o[i] <= flags.outputs_enabled & (mod_cnt < active_width_reg[i]);
			end
		end
	end

	assign flags_o = flags;
endmodule // pwg_generator
`default_nettype wire

// File: verification/pwg_generator_sva.sv
// pwg_generator_sva: port assertions for the pulse width generator
`default_nettype none
module pwg_generator_sva (
	input wire logic                sys_clk_i,
	input wire logic                rst_i,
	input wire logic                shift_clock_in_i,
	input wire logic                serial_in_i,
	input wire logic                latch_strobe_pin_i,
	input wire logic                modulation_clock_i,
	input wire logic                open_string_n_i,
	input wire logic                serial_out_o,
	input wire logic                shift_clock_out_o,
	input wire logic [47:0]         channel_o,
	input wire pwg_pkg::pwg_flags_s flags_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [10:0] high_cnt;
	logic [6:0]  calm_cnt;
	logic        mod_q;
	// ==========================================
	// strobe-high time and quiet time
	always_ff @(posedge sys_clk_i) begin
		mod_q    <= modulation_clock_i;
		high_cnt <= (rst_i || !latch_strobe_pin_i) ? 11'h000 : high_cnt + {10'h000, ~&high_cnt};
		calm_cnt <= (rst_i || latch_strobe_pin_i || mod_q != modulation_clock_i) ? 7'h00 : calm_cnt + {6'h00, ~&calm_cnt};
	end
	// ==========================================
	// properties
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_sck_idle;
		$stable(shift_clock_in_i) [*4];
	endsequence
	sequence s_no_strobe;
		!latch_strobe_pin_i [*8];
	endsequence
	property p_clk_copy;
		shift_clock_out_o == shift_clock_in_i;
	endproperty
	property p_out_still;
		s_sck_idle ##0 !latch_strobe_pin_i |-> $stable(serial_out_o);
	endproperty
	property p_off_low;
		!flags_o.outputs_enabled [*3] |-> channel_o == '0;
	endproperty
	property p_blank;
		high_cnt >= 11'h3F2 |-> channel_o == '0 && flags_o == '0;
	endproperty
	property p_flags_quiet;
		s_no_strobe |=> $stable(flags_o);
	endproperty
	property p_sync_cause;
		$rose(flags_o.frame_sync_error) |-> $past(latch_strobe_pin_i, 2) || $past(latch_strobe_pin_i, 4);
	endproperty
	property p_hold_still;
		calm_cnt >= 7'h40 |=> $stable(channel_o);
	endproperty
	property p_release_clear;
		$fell(rst_i) |-> channel_o == '0 && flags_o == '0;
	endproperty
	a_clk_copy: assert property (p_clk_copy) else $error("shift clock copy wrong");
	a_out_still: assert property (p_out_still) else $error("serial out moved");
	a_off_low: assert property (p_off_low) else $error("output high while off");
	a_blank: assert property (p_blank) else $error("long strobe not blanking");
	a_flags_quiet: assert property (p_flags_quiet) else $error("flags moved");
	a_sync_cause: assert property (p_sync_cause) else $error("sync error without strobe");
	a_hold_still: assert property (p_hold_still) else $error("outputs moved");
	a_release_clear: assert property (p_release_clear) else $error("not clear");
endmodule // pwg_generator_sva
bind pwg_generator pwg_generator_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.shift_clock_in_i(shift_clock_in_i), .serial_in_i(serial_in_i), .latch_strobe_pin_i(latch_strobe_pin_i),
	.modulation_clock_i(modulation_clock_i), .open_string_n_i(open_string_n_i), .serial_out_o(serial_out_o),
	.shift_clock_out_o(shift_clock_out_o), .channel_o(channel_o), .flags_o(flags_o));
`default_nettype wire

// File: verification/pwg_host_model.sv
// pwg_host_model: host controller sending frames and reading status back
`default_nettype none
module pwg_host_model (
	output logic         shift_clock_in_o,
	output logic         serial_in_o,
	output logic         latch_strobe_pin_o,
	input  wire logic    serial_out_i,
	output logic [583:0] status_o,
	output logic         status_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		shift_clock_in_o = 1'b0;
		serial_in_o = 1'b0;
		latch_strobe_pin_o = 1'b0;
		status_o = '0;
		status_done_o = 1'b0;
	end
	// ==========================================
	// one frame, clock runs only inside it
	task automatic send(input logic [583:0] frame, input int nbits, input int hold_ns);
		status_o = '0;
		for (int i = 0; i < nbits; i++) begin
			serial_in_o = frame[583 - i];
			#40 shift_clock_in_o = 1'b1;
			#40 if (i < 583) status_o[582 - i] = serial_out_i;
			#40 shift_clock_in_o = 1'b0;
			#40;
		end
		serial_in_o = ~serial_in_o;
		if (hold_ns > 0) begin
			#100 latch_strobe_pin_o = 1'b1;
			#(hold_ns) latch_strobe_pin_o = 1'b0;
			#4000;
		end
		if (nbits == 584) begin
			status_done_o = 1'b1;
			#10 status_done_o = 1'b0;
		end
	endtask
endmodule // pwg_host_model
`default_nettype wire

// File: verification/pwg_generator_tb.sv
// pwg_generator_tb: self-checking bench of the pulse width generator
`default_nettype none
module pwg_generator_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                sys_clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                mod_clk = 1'b0;
	logic                open_n = 1'b1;
	wire                 sck, serial_in, strobe, serial_out, sck_out, st_done;
	logic [47:0]         ch, exp_ch, flt = '0;
	logic [583:0]        st_rx, last_st = '0;
	pwg_pkg::pwg_flags_s fl, ef = '0;
	logic [11:0]         nom [48], act [48], stg [48];
	logic [5:0]          trim [48];
	int                  n_mismatch = 0, comparisons = 0, mod_cnt = 0, nfull = 0;
	logic [583:0]        q_st [$];
	logic [47:0]         q_ch [$];
	pwg_pkg::pwg_flags_s q_fl [$];
	event                look;
	always #25 sys_clk_i = ~sys_clk_i;
	pwg_generator dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .shift_clock_in_i(sck), .serial_in_i(serial_in),
		.latch_strobe_pin_i(strobe), .modulation_clock_i(mod_clk), .open_string_n_i(open_n),
		.serial_out_o(serial_out), .shift_clock_out_o(sck_out), .channel_o(ch), .flags_o(fl));
	pwg_host_model host (.shift_clock_in_o(sck), .serial_in_o(serial_in), .latch_strobe_pin_o(strobe),
		.serial_out_i(serial_out), .status_o(st_rx), .status_done_o(st_done));
	// ==========================================
	// comparison and verdict
	task automatic tally(input bit ok, input string what);
		comparisons++;
		if (!ok) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic cmp_ch(input logic [47:0] g, input logic [47:0] e);
		tally(g === e, "channel outputs");
	endtask
	task automatic cmp_fl(input pwg_pkg::pwg_flags_s g, input pwg_pkg::pwg_flags_s e);
		tally(g === e, "flags");
	endtask
	task automatic cmp_st(input logic [583:0] g, input logic [583:0] e);
		tally(g === e, "status frame");
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(look) begin
		cmp_ch(ch, q_ch.pop_front());
		cmp_fl(fl, q_fl.pop_front());
	end
	always @(posedge st_done) if (q_st.size() > 0) cmp_st(st_rx, q_st.pop_front());
	initial begin
		#4_500_000;
		n_mismatch++;
		give_verdict();
	end
	// ==========================================
	// reference model and stimulus
	function automatic logic [11:0] scale(input int i);
		return ef.scaling_disable ? nom[i] : 12'((int'(nom[i]) * (int'(trim[i]) + 32) * 2) / (3 * 64));
	endfunction
	task automatic check();
		foreach (act[i]) exp_ch[i] = ef.outputs_enabled && (act[i] > 12'(mod_cnt));
		q_ch.push_back(exp_ch);
		q_fl.push_back(ef);
		@(negedge sys_clk_i);
		->look;
	endtask
	task automatic run_mod(input int n);
		@(negedge sys_clk_i);
		repeat (n) begin
			#100 mod_clk = 1'b1;
			#100 mod_clk = 1'b0;
		end
		if (mod_cnt + n >= 4096) act = stg;
		mod_cnt = (mod_cnt + n) % 4096;
		#500;
	endtask
	task automatic frame(input logic [7:0] cmd, input int nbits = 584, input int hold = 400);
		logic [583:0] f;
		f[7:0] = cmd;
		foreach (nom[i]) f[8 + 12 * i +: 12] = (cmd[7:4] == 4'h2) ? {nom[i][11:6], trim[i]} : nom[i];
		if (nbits == 584 && nfull >= 1) q_st.push_back(last_st);
		host.send(f << (584 - nbits), nbits, hold);
		if (hold > 5000) begin
			ef = '0;
			return;
		end
		nfull += int'(nbits == 584);
		ef.frame_sync_error = (nbits != 584);
		case (cmd[7:4])
			4'h0, 4'h1: foreach (nom[i]) stg[i] = scale(i);
			4'h3: begin
				if (!ef.outputs_enabled) mod_cnt = 0;
				ef.outputs_enabled = 1'b1;
			end
			4'h4: ef.outputs_enabled = 1'b0;
			4'h5: ef.open_self_test = ~ef.open_self_test;
			4'h6: ef.phase_offset_on = ~ef.phase_offset_on;
			4'h7: ef.scaling_disable = ~ef.scaling_disable;
			default: ;
		endcase
		if (cmd[7:4] == 4'h1) act = stg;
		last_st = '0;
		last_st[7:0] = {cmd[7:4], ef.open_self_test, ef.frame_sync_error, ef.phase_offset_on, ef.scaling_disable};
		foreach (trim[i]) last_st[8 + 12 * i +: 12] = {5'h00, flt[i], trim[i]};
		flt = '0;
	endtask
	initial begin
		void'($urandom(22));
		foreach (nom[i]) begin
			nom[i] = 12'($urandom);
			trim[i] = 6'($urandom);
			act[i] = 12'h000;
			stg[i] = 12'h000;
		end
		fork
			host.send('0, 4, 0);
		join_none
		repeat (16) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		check();
		frame(8'h20);
		frame(8'h10);
		check();
		frame(8'h30);
		check();
		run_mod($urandom_range(200, 1500));
		check();
		foreach (nom[i]) nom[i] = 12'($urandom);
		frame(8'h00);
		check();
		run_mod(4096 - mod_cnt);
		check();
		open_n = 1'b0;
		repeat (20) @(negedge sys_clk_i);
		open_n = 1'b1;
		flt = exp_ch;
		for (int c = 4; c < 16; c++) frame({c[3:0], 4'h0});
		check();
		frame(8'h30);
		foreach (nom[i]) nom[i] = 12'($urandom);
		frame(8'h10);
		run_mod($urandom_range(200, 1500));
		check();
		frame(8'h60, 296);
		check();
		frame(8'h00);
		frame(8'h00, 0, 55000);
		check();
		give_verdict();
	end
endmodule // pwg_generator_tb
`default_nettype wire
